// [hw/dmtc_pkg.sv]
// Package with register map, field positions and types of the dual mode timer/counter.
package dmtc_pkg;
  // Register byte addresses on APB (one register per aligned word).
  localparam logic [7:0] ADDR_CTRL  = 8'h88;
  localparam logic [7:0] ADDR_MODE  = 8'h8c;
  localparam logic [7:0] ADDR_CL0   = 8'h90;
  localparam logic [7:0] ADDR_CL1   = 8'h94;
  localparam logic [7:0] ADDR_CH0   = 8'h98;
  localparam logic [7:0] ADDR_CH1   = 8'h9c;
  localparam logic [7:0] ADDR_XCTL  = 8'ha0;
  localparam logic [7:0] ADDR_RLO0  = 8'ha4;
  localparam logic [7:0] ADDR_RLO1  = 8'ha8;
  localparam logic [7:0] ADDR_RHI0  = 8'hac;
  localparam logic [7:0] ADDR_RHI1  = 8'hb0;
  localparam logic [7:0] ADDR_PRESC = 8'hb4;
  localparam logic [7:0] ADDR_ACK   = 8'hb8;

  // Control register bit positions.
  localparam int CTL_OVF1 = 7;
  localparam int CTL_RUN1 = 6;
  localparam int CTL_OVF0 = 5;
  localparam int CTL_RUN0 = 4;
  localparam int CTL_EDG1 = 3;
  localparam int CTL_TYP1 = 2;
  localparam int CTL_EDG0 = 1;
  localparam int CTL_TYP0 = 0;

  // Mode register bit positions per unit, base 4 for unit 1 and 0 for unit 0.
  localparam int MODE_GATE = 3;
  localparam int MODE_CT   = 2;
  localparam int MODE_HI   = 1;
  localparam int MODE_LO   = 0;
  localparam int UNIT_SPAN = 4;

  // Extended control: prescale width field of unit 0 at 2:0, unit 1 at 5:3.
  localparam int PWID0_LSB = 0;
  localparam int PWID1_LSB = 3;
  localparam int PWID_W    = 3;

  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [7:0]  RST_MODE = 8'h00;
  localparam logic [7:0]  RST_XCTL = 8'h24;
  localparam logic [7:0]  RST_RLD  = 8'h00;
  localparam logic [3:0]  RST_PRESC = 4'h0;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    DMTC_MODE_VAR,
    DMTC_MODE_R16,
    DMTC_MODE_R8,
    DMTC_MODE_SPLIT
  } dmtc_mode_type;

  // Per-unit control fields taken from the mode register.
  typedef struct packed {
    logic          gate;
    logic          ct;
    dmtc_mode_type mode;
  } dmtc_unit_cfg_type;
endpackage

// [hw/dmtc_timer.sv]
// Two timer/counter units with a shared prescaler behind an APB slave.
module dmtc_timer (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External pins.
  input  wire logic        count_pin_0,
  input  wire logic        count_pin_1,
  input  wire logic        ext_gate_input_0,
  input  wire logic        ext_gate_input_1,
  // Interrupt side: vector acknowledges and flag outputs.
  input  wire logic [3:0]  vector_ack,
  output logic      [3:0]  irq_flags,
  output logic             unit1_overflow_pulse
);
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] xctl_r;
  logic [3:0] presc_r;
  logic [3:0] presc_cnt_r;
  logic [7:0] cl_r [2];
  logic [7:0] ch_r [2];
  logic [7:0] rl_r [2];
  logic [7:0] rh_r [2];
  logic [7:0] pre_r [2];
  logic [1:0] cpin_r;
  logic [1:0] gin_r;
  logic       tick;
  logic       wr_en;
  logic       rd_en;
  logic [1:0] ovf;
  logic       ovf_hi0;
  logic [1:0] edge_irq;

  function automatic dmtc_pkg::dmtc_unit_cfg_type unit_cfg(input logic [7:0] m, input int u);
    unit_cfg = dmtc_pkg::dmtc_unit_cfg_type'(m[u*dmtc_pkg::UNIT_SPAN +: dmtc_pkg::UNIT_SPAN]);
  endfunction

  // Prescale mask of 1..8 bits from the 3-bit field.
  function automatic logic [7:0] pre_mask(input logic [2:0] w);
    pre_mask = 8'hff >> (3'h7 - w);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // The slave answers in the first access cycle; pready is registered high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end
  end

  // Shared prescaler: one tick every presc_r+1 clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_r <= dmtc_pkg::RST_PRESC;
    end else if (presc_cnt_r >= presc_r) begin
      presc_cnt_r <= dmtc_pkg::RST_PRESC;
    end else begin
      presc_cnt_r <= presc_cnt_r + 4'h1;
    end
  end
  assign tick = (presc_cnt_r >= presc_r);

  // Pin samplers; a falling edge is previous high and current low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpin_r <= 2'h3;
      gin_r  <= 2'h3;
    end else begin
      cpin_r <= {count_pin_1, count_pin_0};
      gin_r  <= {ext_gate_input_1, ext_gate_input_0};
    end
  end

  // Counter engine for both units.
  logic [1:0] run;
  logic [1:0] inc;
  logic       run_hi0;
  dmtc_pkg::dmtc_unit_cfg_type cfg [2];
  logic [7:0] cl_nxt [2];
  logic [7:0] ch_nxt [2];
  logic [7:0] pre_nxt [2];

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      cfg[u] = unit_cfg(mode_r, u);
    end
    run[0] = ctrl_r[dmtc_pkg::CTL_RUN0] && (!cfg[0].gate || gin_r[0]);
    run[1] = ctrl_r[dmtc_pkg::CTL_RUN1] && (!cfg[1].gate || gin_r[1])
             && (cfg[1].mode != dmtc_pkg::DMTC_MODE_SPLIT);
    run_hi0 = ctrl_r[dmtc_pkg::CTL_RUN1] && tick;
    for (int u = 0; u < 2; u++) begin
      inc[u] = run[u] && (cfg[u].ct ? (cpin_r[u] && !(u == 0 ? count_pin_0 : count_pin_1))
                                   : tick);
      cl_nxt[u]  = cl_r[u];
      ch_nxt[u]  = ch_r[u];
      pre_nxt[u] = pre_r[u];
      ovf[u]     = 1'b0;
    end
    ovf_hi0 = 1'b0;
    for (int u = 0; u < 2; u++) begin
      unique case (cfg[u].mode)
        dmtc_pkg::DMTC_MODE_VAR: begin
          // The prescale part lives in the low byte under the width mask.
          if (inc[u]) begin
            pre_nxt[u] = (cl_r[u] + 8'h01) & pre_mask(u == 0
              ? xctl_r[dmtc_pkg::PWID0_LSB +: dmtc_pkg::PWID_W]
              : xctl_r[dmtc_pkg::PWID1_LSB +: dmtc_pkg::PWID_W]);
            cl_nxt[u] = pre_nxt[u];
            if (pre_nxt[u] == 8'h00) begin
              ch_nxt[u] = ch_r[u] + 8'h01;
              ovf[u] = (ch_r[u] == 8'hff);
            end
          end
        end
        dmtc_pkg::DMTC_MODE_R16: begin
          if (inc[u]) begin
            if ({ch_r[u], cl_r[u]} == 16'hffff) begin
              {ch_nxt[u], cl_nxt[u]} = {rh_r[u], rl_r[u]};
              ovf[u] = 1'b1;
            end else begin
              {ch_nxt[u], cl_nxt[u]} = {ch_r[u], cl_r[u]} + 16'h0001;
            end
          end
        end
        dmtc_pkg::DMTC_MODE_R8: begin
          if (inc[u]) begin
            if (cl_r[u] == 8'hff) begin
              cl_nxt[u] = ch_r[u];
              ovf[u] = 1'b1;
            end else begin
              cl_nxt[u] = cl_r[u] + 8'h01;
            end
          end
        end
        dmtc_pkg::DMTC_MODE_SPLIT: begin
          if (u == 0) begin
            if (inc[0]) begin
              cl_nxt[0] = cl_r[0] + 8'h01;
              ovf[0] = (cl_r[0] == 8'hff);
            end
            if (run_hi0) begin
              ch_nxt[0] = ch_r[0] + 8'h01;
              ovf_hi0 = (ch_r[0] == 8'hff);
            end
          end
        end
      endcase
    end
  end

  // Edge flags: falling edge or low level per the type bit.
  assign edge_irq[0] = ctrl_r[dmtc_pkg::CTL_TYP0] ? (gin_r[0] && !ext_gate_input_0)
                                                 : !ext_gate_input_0;
  assign edge_irq[1] = ctrl_r[dmtc_pkg::CTL_TYP1] ? (gin_r[1] && !ext_gate_input_1)
                                                 : !ext_gate_input_1;

  logic split0;
  logic set_tf1;
  assign split0  = (cfg[0].mode == dmtc_pkg::DMTC_MODE_SPLIT);
  assign set_tf1 = split0 ? ovf_hi0 : ovf[1];

  // Counts and reload storage; software writes win for their own byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int u = 0; u < 2; u++) begin
        cl_r[u]  <= 8'h00;
        ch_r[u]  <= 8'h00;
        pre_r[u] <= 8'h00;
        rl_r[u]  <= dmtc_pkg::RST_RLD;
        rh_r[u]  <= dmtc_pkg::RST_RLD;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        cl_r[u]  <= cl_nxt[u];
        ch_r[u]  <= ch_nxt[u];
        pre_r[u] <= pre_nxt[u];
      end
      if (wr_en) begin
        unique case (paddr)
          dmtc_pkg::ADDR_CL0: cl_r[0] <= pwdata[7:0];
          dmtc_pkg::ADDR_CL1: cl_r[1] <= pwdata[7:0];
          dmtc_pkg::ADDR_CH0: ch_r[0] <= pwdata[7:0];
          dmtc_pkg::ADDR_CH1: ch_r[1] <= pwdata[7:0];
          dmtc_pkg::ADDR_RLO0: rl_r[0] <= pwdata[7:0];
          dmtc_pkg::ADDR_RLO1: rl_r[1] <= pwdata[7:0];
          dmtc_pkg::ADDR_RHI0: rh_r[0] <= pwdata[7:0];
          dmtc_pkg::ADDR_RHI1: rh_r[1] <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Control register; a hardware set wins over a clear in the same cycle.
  logic [7:0] hw_set;
  logic [7:0] ack_clr;
  always_comb begin
    hw_set = 8'h00;
    hw_set[dmtc_pkg::CTL_OVF0] = ovf[0];
    hw_set[dmtc_pkg::CTL_OVF1] = set_tf1;
    hw_set[dmtc_pkg::CTL_EDG0] = edge_irq[0];
    hw_set[dmtc_pkg::CTL_EDG1] = edge_irq[1];
    ack_clr = 8'h00;
    ack_clr[dmtc_pkg::CTL_OVF0] = vector_ack[0];
    ack_clr[dmtc_pkg::CTL_OVF1] = vector_ack[1];
    ack_clr[dmtc_pkg::CTL_EDG0] = vector_ack[2];
    ack_clr[dmtc_pkg::CTL_EDG1] = vector_ack[3];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= dmtc_pkg::RST_CTRL;
    end else if (wr_en && paddr == dmtc_pkg::ADDR_CTRL) begin
      ctrl_r <= pwdata[7:0] | hw_set;
    end else begin
      ctrl_r <= (ctrl_r & ~ack_clr) | hw_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r  <= dmtc_pkg::RST_MODE;
      xctl_r  <= dmtc_pkg::RST_XCTL;
      presc_r <= dmtc_pkg::RST_PRESC;
    end else if (wr_en) begin
      if (paddr == dmtc_pkg::ADDR_MODE) begin
        mode_r <= pwdata[7:0];
      end
      if (paddr == dmtc_pkg::ADDR_XCTL) begin
        xctl_r <= pwdata[7:0];
      end
      if (paddr == dmtc_pkg::ADDR_PRESC) begin
        presc_r <= pwdata[3:0];
      end
    end
  end

  // Read data registered at the setup cycle (psel high, penable low).
  logic [7:0] rd_byte;
  always_comb begin
    unique case (paddr)
      dmtc_pkg::ADDR_CTRL:  rd_byte = ctrl_r;
      dmtc_pkg::ADDR_MODE:  rd_byte = mode_r;
      dmtc_pkg::ADDR_CL0:   rd_byte = cl_r[0];
      dmtc_pkg::ADDR_CL1:   rd_byte = cl_r[1];
      dmtc_pkg::ADDR_CH0:   rd_byte = ch_r[0];
      dmtc_pkg::ADDR_CH1:   rd_byte = ch_r[1];
      dmtc_pkg::ADDR_XCTL:  rd_byte = xctl_r;
      dmtc_pkg::ADDR_RLO0:  rd_byte = rl_r[0];
      dmtc_pkg::ADDR_RLO1:  rd_byte = rl_r[1];
      dmtc_pkg::ADDR_RHI0:  rd_byte = rh_r[0];
      dmtc_pkg::ADDR_RHI1:  rd_byte = rh_r[1];
      dmtc_pkg::ADDR_PRESC: rd_byte = {4'h0, presc_r};
      default:              rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= dmtc_pkg::RD_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags            <= 4'h0;
      unit1_overflow_pulse <= 1'b0;
    end else begin
      irq_flags <= {ctrl_r[dmtc_pkg::CTL_EDG1], ctrl_r[dmtc_pkg::CTL_EDG0],
                    ctrl_r[dmtc_pkg::CTL_OVF1], ctrl_r[dmtc_pkg::CTL_OVF0]};
      unit1_overflow_pulse <= ovf[1]; // Baud source even while split.
    end
  end
endmodule

// [verification/dmtc_timer_properties.sv]
// Checker of the APB answers and the unit 0 edge flag output of the timer block.
module dmtc_timer_properties (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Gate pin and flags.
  input wire logic        ext_gate_input_0,
  input wire logic [3:0]  vector_ack,
  input wire logic [3:0]  irq_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_no_err; psel && penable |-> !pslverr; endproperty
  property p_ready; psel && penable |-> pready; endproperty
  property p_ready_up; $past(presetn) |-> pready; endproperty
  property p_hi_zero; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  property p_unmapped; psel && !penable && !pwrite && paddr == 8'h04 |=> prdata == 32'h0;
  endproperty
  property p_rdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  // The pin must stay low so that a level trigger cannot drop the flag either.
  property p_edge_set;
    $fell(ext_gate_input_0) ##1 (!ext_gate_input_0 && !vector_ack[2])[*6] |-> irq_flags[2];
  endproperty
  property p_ack_clr;
    ext_gate_input_0[*3] ##0 vector_ack[2] ##1 ext_gate_input_0[*3] |-> !irq_flags[2];
  endproperty
  a_no_err: assert property (p_no_err) else $error("slave error raised");
  a_ready: assert property (p_ready) else $error("access without ready");
  a_ready_up: assert property (p_ready_up) else $error("ready low after reset");
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");
  a_ack_clr: assert property (p_ack_clr) else $error("edge flag not cleared");
  c_write: cover property (psel && penable && pwrite);
  c_ack: cover property (vector_ack[2]);
  c_flag: cover property (irq_flags[0]);
endmodule

// [verification/dmtc_pin_model.sv]
// Behavioural source for the count pins and gate inputs of the timer block.
module dmtc_pin_model (
  // Clock.
  input wire logic pclk,
  // Pins.
  output logic     count_pin_0,
  output logic     count_pin_1,
  output logic     ext_gate_input_0,
  output logic     ext_gate_input_1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q = 2'b11;
  logic [1:0] gate_q = 2'b11;
  assign count_pin_0 = cnt_q[0];
  assign count_pin_1 = cnt_q[1];
  assign ext_gate_input_0 = gate_q[0];
  assign ext_gate_input_1 = gate_q[1];
  // Each level stands two clocks, so every level is sampled at least once.
  task automatic pulses(input logic u, input int n);
    repeat (n) begin
      repeat (2) @(posedge pclk);
      cnt_q[u] <= 1'b0;
      repeat (2) @(posedge pclk);
      cnt_q[u] <= 1'b1;
    end
  endtask
  task automatic set_gate(input logic u, input logic v);
    @(posedge pclk);
    gate_q[u] <= v;
  endtask
endmodule

// [verification/dmtc_timer_tb.sv]
// Self-checking bench for the dual mode timer/counter block.
module dmtc_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        c0;
  logic        c1;
  logic        g0;
  logic        g1;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [3:0]  vector_ack;
  logic [3:0]  irq_flags;
  logic        u1p;
  int          miscompares;
  int          checks;
  int          u1p_cnt = 0;
  int          u1p_base;

  dmtc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_0(c0), .count_pin_1(c1), .ext_gate_input_0(g0),
    .ext_gate_input_1(g1), .vector_ack(vector_ack), .irq_flags(irq_flags),
    .unit1_overflow_pulse(u1p));
  dmtc_pin_model pm (.pclk(pclk), .count_pin_0(c0), .count_pin_1(c1),
    .ext_gate_input_0(g0), .ext_gate_input_1(g1));

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    if (pready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic ack(input logic [3:0] b);
    @(posedge pclk);
    vector_ack <= b;
    @(posedge pclk);
    vector_ack <= 4'h0;
  endtask

  // Unit 1 overflow pulses are counted so they can be checked while unit 0 is split.
  always @(posedge pclk) begin
    if (u1p === 1'b1) begin
      u1p_cnt <= u1p_cnt + 1;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vector_ack = 4'h0;
    miscompares = 0;
    checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc(dmtc_pkg::ADDR_CTRL, 32'h00);
    rc(dmtc_pkg::ADDR_XCTL, 32'h24);
    rc(dmtc_pkg::ADDR_RHI0, 32'h00);
    rc(8'h04, 32'h00);
    $display("test reset done");
    // Unit 0 as gated 16-bit reload counter, preloaded one step short of all ones.
    wr(dmtc_pkg::ADDR_RLO0, 8'h34);
    wr(dmtc_pkg::ADDR_RHI0, 8'h12);
    wr(dmtc_pkg::ADDR_CL0, 8'hfe);
    wr(dmtc_pkg::ADDR_CH0, 8'hff);
    wr(dmtc_pkg::ADDR_MODE, 8'h0d);
    wr(dmtc_pkg::ADDR_CTRL, 8'h10);
    pm.set_gate(1'b0, 1'b0);
    pm.pulses(1'b0, 2);
    rc(dmtc_pkg::ADDR_CL0, 32'hfe);
    chk(irq_flags, 32'h4);
    pm.set_gate(1'b0, 1'b1);
    pm.pulses(1'b0, 3);
    rc(dmtc_pkg::ADDR_CL0, 32'h35);
    rc(dmtc_pkg::ADDR_CH0, 32'h12);
    rc(dmtc_pkg::ADDR_CTRL, 32'h32);
    wr(dmtc_pkg::ADDR_CTRL, 8'h00);
    ack(4'h5);
    rc(dmtc_pkg::ADDR_CTRL, 32'h00);
    $display("test reload16 done");
    wr(dmtc_pkg::ADDR_RLO1, 8'h5a);
    wr(dmtc_pkg::ADDR_CH1, 8'h80);
    wr(dmtc_pkg::ADDR_CL1, 8'hff);
    wr(dmtc_pkg::ADDR_MODE, 8'h60);
    wr(dmtc_pkg::ADDR_CTRL, 8'h40);
    pm.pulses(1'b1, 1);
    rc(dmtc_pkg::ADDR_CL1, 32'h80);
    rc(dmtc_pkg::ADDR_CH1, 32'h80);
    rc(dmtc_pkg::ADDR_RLO1, 32'h5a);
    ack(4'h2);
    wr(dmtc_pkg::ADDR_MODE, 8'h70);
    pm.pulses(1'b1, 2);
    rc(dmtc_pkg::ADDR_CL1, 32'h80);
    rc(dmtc_pkg::ADDR_CTRL, 32'h40);
    $display("test reload8 and hold done");
    // One prescale bit below the high byte gives a 9-bit count.
    wr(dmtc_pkg::ADDR_XCTL, 8'h20);
    wr(dmtc_pkg::ADDR_CH0, 8'hff);
    wr(dmtc_pkg::ADDR_CL0, 8'h01);
    wr(dmtc_pkg::ADDR_MODE, 8'h74);
    wr(dmtc_pkg::ADDR_CTRL, 8'h50);
    pm.pulses(1'b0, 1);
    rc(dmtc_pkg::ADDR_CH0, 32'h00);
    xfer(1'b0, dmtc_pkg::ADDR_CL0, 8'h00);
    chk(q & 32'h1, 32'h0);
    chk(q & 32'hffffff00, 32'h0);
    rc(dmtc_pkg::ADDR_CTRL, 32'h70);
    $display("test width9 done");
    // Unit 0 split: high byte times clocks on unit 1's run bit, unit 1 runs flagless.
    wr(dmtc_pkg::ADDR_CTRL, 8'h00);
    wr(dmtc_pkg::ADDR_CH0, 8'hff);
    wr(dmtc_pkg::ADDR_MODE, 8'h23);
    u1p_base = u1p_cnt;
    wr(dmtc_pkg::ADDR_CTRL, 8'h40);
    repeat (300) @(posedge pclk);
    rc(dmtc_pkg::ADDR_CTRL, 32'hc0);
    rc(dmtc_pkg::ADDR_CL0, 32'h00);
    chk(u1p_cnt > u1p_base, 32'h1);
    $display("test split done");
    end_sim();
  end
endmodule

bind dmtc_timer dmtc_timer_properties chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_gate_input_0(ext_gate_input_0), .vector_ack(vector_ack),
  .irq_flags(irq_flags));
